// file: rwd_chk.sv
// Purpose: Port assertions for rwd_top
// Assumes: One clock domain, pclk
// Notes:   Shadows the option word from APB writes
`timescale 1ns/100ps
`include "rwd_consts.svh"
// ==========================================
// Checker
module rwd_chk (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [11:0]        paddr,
  input wire logic [31:0]        pwdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic               chip_clear_input,
  input wire rwd_pkg::rwd_outs_t outs,
  input wire logic               sys_reset,
  input wire logic               cpu_clk_en,
  input wire logic               primary_oscillator,
  input wire logic               irq_req,
  input wire logic [3:0]         irq_vector
);
  import rwd_pkg::*;
  logic [11:0] opt_q;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Option word shadow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opt_q <= 12'h000;
    end else if (psel && penable && pwrite && paddr == `RWD_OFF_OPT) begin
      opt_q <= pwdata[11:0];
    end
  end
  // Bus answer timing
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_once: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  // Reset, clocks and vectors
  a_clear_reset: assert property (chip_clear_input == opt_q[0] |-> ##[1:3] sys_reset)
    else $error("clear pin did not reset");
  a_reset_levels: assert property (sys_reset && $past(sys_reset) |-> outs == opt_q[11:8])
    else $error("wrong output level in reset");
  a_reset_clk: assert property (sys_reset |-> !cpu_clk_en)
    else $error("clock runs in reset");
  a_hold_clk: assert property (!primary_oscillator |-> !cpu_clk_en)
    else $error("clock runs with oscillator off");
  a_vec_valid: assert property (irq_req |-> irq_vector inside {[4'h1:4'h4]})
    else $error("bad vector");
endmodule

bind rwd_top rwd_chk rwd_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .chip_clear_input(chip_clear_input), .outs(outs), .sys_reset(sys_reset), .cpu_clk_en(cpu_clk_en),
  .primary_oscillator(primary_oscillator), .irq_req(irq_req), .irq_vector(irq_vector));

// file: rwd_consts.svh
// Purpose: Constants for the reset, wake and decade counter block
// Assumes: pclk at 25 MHz, APB word-aligned registers
// Notes:   Offsets are byte addresses
`ifndef RWD_CONSTS_SVH
`define RWD_CONSTS_SVH
// ==========================================================
// Register offsets
`define RWD_OFF_CTRL   12'h000
`define RWD_OFF_WAKEEN 12'h004
`define RWD_OFF_INTEN  12'h008
`define RWD_OFF_STAT   12'h00C
`define RWD_OFF_COUNT  12'h010
`define RWD_OFF_OPT    12'h014
`define RWD_OFF_CMD    12'h018
`define RWD_OFF_TIMER  12'h01C
// ==========================================================
// Command codes written to CMD
`define RWD_CMD_HALT   4'h1
`define RWD_CMD_STOP   4'h2
`define RWD_CMD_IRET   4'h3
// ==========================================================
// Source bit positions
`define RWD_SRC_EXT    0
`define RWD_SRC_PORT   1
`define RWD_SRC_TMR    2
`define RWD_SRC_DIV    3
`define RWD_SRC_CNT    4
// ==========================================================
// Vector addresses
`define RWD_VEC_EXT    4'h1
`define RWD_VEC_TMR    4'h2
`define RWD_VEC_DIV    4'h3
`define RWD_VEC_CNT    4'h4
// ==========================================================
// Divider: chain length, reset-cleared portion, hundredths tick
`define RWD_DIV_BITS   15
`define RWD_DIV_CLRMSK 15'h00FF
`define RWD_CS_PERIOD  16'h0147
// Reset values
`define RWD_OPT_RST    12'h000
`endif

// file: rwd_ext_model.sv
// Purpose: Switches, keys and pulse sources at the pins
// Assumes: Levels change just after a pclk edge
// Notes:   Clear pin idles high as if pulled up
`timescale 1ns/100ps
// ==========================================
// Pin model
module rwd_ext_model (
  input  wire logic          pclk,
  output logic               chip_clear_input,
  output rwd_pkg::rwd_pins_t pins
);
  import rwd_pkg::*;
  // Idle levels
  initial begin
    chip_clear_input = 1'b1;
    pins = '0;
  end
  // Low pulse on the clear pin
  task automatic clear_pulse(input int n);
    @(posedge pclk) chip_clear_input <= 1'b0;
    repeat (n) @(posedge pclk);
    chip_clear_input <= 1'b1;
  endtask
  // Count pulses at a fixed direction level
  task automatic count(input logic dir, input int n);
    repeat (n) begin
      @(posedge pclk) pins.key_port[1] <= dir;
      @(posedge pclk) pins.key_port[3] <= 1'b1;
      @(posedge pclk) pins.key_port[3] <= 1'b0;
    end
  endtask
  task automatic ext(input logic v);
    @(posedge pclk) pins.ext_int <= v;
  endtask
  task automatic underflow();
    @(posedge pclk) pins.timer_uf <= 1'b1;
    @(posedge pclk) pins.timer_uf <= 1'b0;
  endtask
  task automatic switches(input logic [3:0] v);
    @(posedge pclk) pins.switch_input_port <= v;
  endtask
endmodule

// file: rwd_pkg.sv
// Purpose: Types for the reset, wake and decade counter block
// Assumes: Constants come from rwd_consts.svh
// Notes:   Types only
package rwd_pkg;
  typedef enum logic [3:0] {
    RWD_RUN   = 4'b0001,
    RWD_HALT  = 4'b0010,
    RWD_HOLD  = 4'b0100,
    RWD_SVC   = 4'b1000
  } rwd_mode_t;
  typedef struct packed {
    logic [3:0] switch_input_port;
    logic [3:0] key_port;
    logic       ext_int;
    logic       timer_uf;
  } rwd_pins_t;
  typedef struct packed {
    logic control_output_one;
    logic control_output_two;
    logic alarm_out;
    logic lamp_out;
  } rwd_outs_t;
endpackage

// file: rwd_top.sv
// Purpose: Reset sequencing, interrupt vectors, HALT/HOLD and decade counter
// Assumes: All pin inputs synchronous to pclk; APB slave for registers
// Notes:   Divider chain runs from pclk as the oscillator stand-in
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`include "rwd_consts.svh"

// Functional notes
// [R1] Clear input sets flag, clears low divider
// [R2] Hold reset until divider overflow clears flag
// [R3] Optional four-switch simultaneous initial clear
// [R4] Five request sources, four vectors
// [R5] Ext pin and port change share vector
// [R6] HALT command stops CPU clock
// [R7] In HALT only oscillator, wake, LCD run; here the decade counter also keeps counting in HALT
// [R8] Five sources make HALT wake requests
// [R9] Wake enables independent of interrupt enables
// [R10] Interrupt in HALT serviced, then HALT again
// [R11] STOP command enters HOLD, oscillator stops
// [R12] RC plus crystal: reset, irq, wake exit
// [R13] Other oscillators: only reset exits HOLD
// [R14] Crystal only: HOLD unavailable
// [R15] Mode 1: direction by direction key level
// [R16] Mode 2: direction from key phase
// [R17] Mode 3: divider ticks, count up only
// [R18] Clear input polarity is an option
// [R19] Outputs take option level during reset
// [R20] Optional power-on clear at power-up; opt_q[1] is 0 at power-up, so rst_flag_q clears on the first clock
// [R21] Fixed priority ext, timer, divider, counter
module rwd_top (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              chip_clear_input,
  input  wire rwd_pkg::rwd_pins_t pins,
  input  wire logic [3:0]        drive_level,
  output rwd_pkg::rwd_outs_t     outs,
  output logic                   sys_reset,
  output logic                   cpu_clk_en,
  output logic                   primary_oscillator,
  output logic                   irq_req,
  output logic      [3:0]        irq_vector
);
  import rwd_pkg::*;

  // ==========================================================
  // Option and control registers
  // opt: [0] clear active high, [1] power-on clear used, [2] switch clear used,
  //      [4:3] osc kind 0=CR+XTAL 1=CF+XTAL/CR/CF 2=XTAL only, [11:8] reset levels
  logic [11:0] opt_q;
  logic [4:0]  wake_en_q;
  logic [4:0]  int_en_q;
  logic [4:0]  pend_q;
  logic [1:0]  cnt_mode_q;
  logic        cnt_run_q;
  logic [3:0]  out_level_q;
  logic [15:0] bcd_q;
  logic [14:0] div_q;
  logic [15:0] cs_q;
  logic        rst_flag_q;
  logic        por_q;
  logic        ovf_q;
  logic        key_prev_q;
  logic        dir_prev_q;
  logic [7:0]  in_prev_q;
  logic        cnt_evt_q;
  logic        tmr_prev_q;
  rwd_mode_t   mode_q;
  rwd_mode_t   ret_mode_q;

  logic        apb_wr;
  logic        apb_rd;
  logic        clr_active;
  logic        sw_clear;
  logic        div_ovf;
  logic        cs_tick;
  logic [4:0]  src_evt;
  logic [4:0]  int_act;
  logic        wake;
  logic        hold_wake;
  logic        cmd_wr;

  // BCD digit step with carry out
  function automatic logic [4:0] bcd_step(input logic [3:0] d, input logic up);
    if (up) begin
      bcd_step = (d == 4'h9) ? 5'h10 : {1'b0, d + 4'h1};
    end else begin
      bcd_step = (d == 4'h0) ? 5'h19 : {1'b0, d - 4'h1};
    end
  endfunction

  // Bus strobes, one-cycle access
  assign apb_wr = psel & penable & pwrite;
  assign apb_rd = psel & ~penable & ~pwrite;
  assign cmd_wr = apb_wr & (paddr == `RWD_OFF_CMD);

  // Clear input polarity and switch clear
  assign clr_active = opt_q[0] ? chip_clear_input : ~chip_clear_input;        // [R18]
  assign sw_clear   = opt_q[2] & (pins.switch_input_port == 4'hF);            // [R3]

  // ==========================================================
  // Oscillator divider chain, stops in HOLD
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 15'h0000;
    end else if (clr_active) begin
      div_q <= div_q & ~`RWD_DIV_CLRMSK;                                       // [R1]
    end else if (mode_q != RWD_HOLD) begin                                     // [R11]
      div_q <= div_q + 15'h0001;
    end
  end
  assign div_ovf = (div_q == {`RWD_DIV_BITS{1'b1}}) & (mode_q != RWD_HOLD);

  // Hundredths tick from divider clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_q <= 16'h0000;
    end else if (mode_q != RWD_HOLD) begin
      cs_q <= (cs_q == `RWD_CS_PERIOD - 16'h0001) ? 16'h0000 : cs_q + 16'h0001;
    end
  end
  assign cs_tick = (cs_q == `RWD_CS_PERIOD - 16'h0001) & (mode_q != RWD_HOLD);

  // ==========================================================
  // Reset flag: set by clear sources, cleared by divider overflow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_q      <= 1'b1;
      rst_flag_q <= 1'b1;
    end else begin
      por_q <= 1'b0;
      if (clr_active | sw_clear) begin
        rst_flag_q <= 1'b1;                                                    // [R1] [R3]
      end else if (por_q) begin
        rst_flag_q <= opt_q[1];                                                // [R20]
      end else if (div_ovf) begin
        rst_flag_q <= 1'b0;                                                    // [R2]
      end
    end
  end

  // ==========================================================
  // Options are straps held outside reset flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opt_q <= `RWD_OPT_RST;
    end else if (apb_wr & (paddr == `RWD_OFF_OPT)) begin
      opt_q <= pwdata[11:0];
    end
  end

  // Software control registers, cleared by internal reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_en_q   <= 5'h00;
      int_en_q    <= 5'h00;
      cnt_mode_q  <= 2'h0;
      cnt_run_q   <= 1'b0;
      out_level_q <= 4'h0;
    end else if (rst_flag_q) begin                                             // [R2]
      wake_en_q   <= 5'h00;
      int_en_q    <= 5'h00;
      cnt_mode_q  <= 2'h0;
      cnt_run_q   <= 1'b0;
      out_level_q <= 4'h0;
    end else if (apb_wr) begin
      case (paddr)
        `RWD_OFF_CTRL: begin
          cnt_mode_q  <= pwdata[1:0];
          cnt_run_q   <= pwdata[2];
          out_level_q <= pwdata[7:4];
        end
        `RWD_OFF_WAKEEN: wake_en_q <= pwdata[4:0];                             // [R9]
        `RWD_OFF_INTEN:  int_en_q  <= pwdata[4:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Event sources and edge history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_prev_q  <= 8'h00;
      tmr_prev_q <= 1'b0;
    end else begin
      in_prev_q  <= {pins.switch_input_port, pins.key_port};
      tmr_prev_q <= pins.timer_uf;
    end
  end

  // Source vector: ext, port change, timer, divider, counter
  always_comb begin
    src_evt                = 5'h00;                                            // [R5]
    src_evt[`RWD_SRC_EXT]  = pins.ext_int;
    src_evt[`RWD_SRC_PORT] = ({pins.switch_input_port, pins.key_port} != in_prev_q);
    src_evt[`RWD_SRC_TMR]  = pins.timer_uf & ~tmr_prev_q;
    src_evt[`RWD_SRC_DIV]  = div_ovf;
    src_evt[`RWD_SRC_CNT]  = cnt_evt_q;
  end

  // ==========================================================
  // Pending flags; new event wins over acknowledge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= 5'h00;
    end else if (rst_flag_q) begin
      pend_q <= 5'h00;
    end else begin
      pend_q <= (pend_q & ~((apb_wr & (paddr == `RWD_OFF_STAT)) ? pwdata[4:0] : 5'h00))
                | src_evt;                                                     // [R4]
    end
  end

  assign int_act   = pend_q & int_en_q;
  assign wake      = |(pend_q & wake_en_q);                                    // [R8] [R9]
  assign hold_wake = (opt_q[4:3] == 2'h0) & (wake | (|int_act));               // [R12] [R13]

  // ==========================================================
  // Power mode machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q     <= RWD_RUN;
      ret_mode_q <= RWD_RUN;
    end else if (rst_flag_q) begin
      mode_q     <= RWD_RUN;                                                   // [R12] [R13]
      ret_mode_q <= RWD_RUN;
    end else begin
      case (mode_q)
        RWD_RUN: begin
          if (|int_act) begin
            mode_q     <= RWD_SVC;
            ret_mode_q <= RWD_RUN;
          end else if (cmd_wr & (pwdata[3:0] == `RWD_CMD_HALT)) begin
            mode_q <= RWD_HALT;                                                // [R6]
          end else if (cmd_wr & (pwdata[3:0] == `RWD_CMD_STOP) & (opt_q[4:3] != 2'h2)) begin
            mode_q <= RWD_HOLD;                                                // [R11] [R14]
          end
        end
        RWD_HALT: begin
          if (|int_act) begin
            mode_q     <= RWD_SVC;                                             // [R10]
            ret_mode_q <= RWD_HALT;
          end else if (wake) begin
            mode_q <= RWD_RUN;                                                 // [R8]
          end
        end
        RWD_HOLD: begin
          if (hold_wake) begin
            mode_q <= RWD_RUN;                                                 // [R12]
          end
        end
        RWD_SVC: begin
          if (cmd_wr & (pwdata[3:0] == `RWD_CMD_IRET)) begin
            mode_q <= ret_mode_q;                                              // [R10]
          end
        end
        default: mode_q <= RWD_RUN;
      endcase
    end
  end

  // ==========================================================
  // Decade counter, four BCD digits, counts while cnt_run_q is set in any power mode; key counting goes on in HALT and HOLD, divider ticks stop in HOLD
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bcd_q      <= 16'h0000;
      key_prev_q <= 1'b0;
      dir_prev_q <= 1'b0;
      cnt_evt_q  <= 1'b0;
    end else begin
      key_prev_q <= pins.key_port[3];
      dir_prev_q <= pins.key_port[1];
      cnt_evt_q  <= 1'b0;
      if (rst_flag_q) begin
        bcd_q <= 16'h0000;
      end else if (apb_wr & (paddr == `RWD_OFF_COUNT)) begin
        bcd_q <= pwdata[15:0];
      end else if (cnt_run_q) begin : step
        logic       pulse;
        logic       up;
        logic [4:0] d0, d1, d2, d3;
        pulse = 1'b0;
        up    = 1'b1;
        case (cnt_mode_q)
          2'h0: begin
            pulse = pins.key_port[3] & ~key_prev_q;                            // [R15]
            up    = pins.key_port[1];                                          // [R15]
          end
          2'h1: begin
            pulse = pins.key_port[3] & ~key_prev_q;                            // [R16]
            up    = ~dir_prev_q;                                               // [R16]
          end
          2'h2: begin
            pulse = cs_tick;                                                   // [R17]
            up    = 1'b1;                                                      // [R17]
          end
          default: pulse = 1'b0;
        endcase
        d0 = bcd_step(bcd_q[3:0], up);
        d1 = bcd_step(bcd_q[7:4], up);
        d2 = bcd_step(bcd_q[11:8], up);
        d3 = bcd_step(bcd_q[15:12], up);
        if (pulse) begin
          bcd_q[3:0] <= d0[3:0];
          if (d0[4]) begin
            bcd_q[7:4] <= d1[3:0];
            if (d1[4]) begin
              bcd_q[11:8] <= d2[3:0];
              if (d2[4]) begin
                bcd_q[15:12] <= d3[3:0];
                cnt_evt_q    <= d3[4];
              end
            end
          end
        end
      end
    end
  end

  // ==========================================================
  // Priority vector encoder
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req    <= 1'b0;
      irq_vector <= 4'h0;
    end else begin
      irq_req <= |int_act;
      if (int_act[`RWD_SRC_EXT] | int_act[`RWD_SRC_PORT]) begin
        irq_vector <= `RWD_VEC_EXT;                                            // [R5] [R21]
      end else if (int_act[`RWD_SRC_TMR]) begin
        irq_vector <= `RWD_VEC_TMR;                                            // [R21]
      end else if (int_act[`RWD_SRC_DIV]) begin
        irq_vector <= `RWD_VEC_DIV;
      end else if (int_act[`RWD_SRC_CNT]) begin
        irq_vector <= `RWD_VEC_CNT;                                            // [R4]
      end else begin
        irq_vector <= 4'h0;
      end
    end
  end

  // ==========================================================
  // System outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_reset          <= 1'b1;
      cpu_clk_en         <= 1'b0;
      primary_oscillator <= 1'b0;
      outs               <= '0;
    end else begin
      sys_reset          <= rst_flag_q;                                        // [R2]
      cpu_clk_en         <= ~rst_flag_q & (mode_q != RWD_HALT) & (mode_q != RWD_HOLD); // [R6] [R7]
      primary_oscillator <= (mode_q != RWD_HOLD);                              // [R11]
      outs               <= rst_flag_q ? opt_q[11:8] : (out_level_q ^ drive_level); // [R19]
    end
  end

  // ==========================================================
  // APB read path, zero wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      if (apb_rd) begin
        case (paddr)
          `RWD_OFF_CTRL:   prdata <= {24'h000000, out_level_q, 1'b0, cnt_run_q, cnt_mode_q};
          `RWD_OFF_WAKEEN: prdata <= {27'h0000000, wake_en_q};
          `RWD_OFF_INTEN:  prdata <= {27'h0000000, int_en_q};
          `RWD_OFF_STAT:   prdata <= {20'h00000, mode_q, 3'h0, pend_q};
          `RWD_OFF_COUNT:  prdata <= {16'h0000, bcd_q};
          `RWD_OFF_OPT:    prdata <= {20'h00000, opt_q};
          `RWD_OFF_CMD:    prdata <= 32'h0000_0000;
          `RWD_OFF_TIMER:  prdata <= {17'h00000, div_q};
          default: begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule

// file: tb_rwd_top.sv
// Purpose: Self-checking bench for rwd_top
// Assumes: Zero-wait APB slave, 25 MHz pclk
// Notes:   Enables and counts modelled in ints
`timescale 1ns/100ps
`include "rwd_consts.svh"
// ==========================================
// Bench
module tb_rwd_top;
  import rwd_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        clr, sys_reset, cpu_clk_en, osc, irq_req, er, up;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  drive_level, irq_vector;
  rwd_pins_t   pins;
  rwd_outs_t   outs;
  int          errors, checked, k, m;
  rwd_top rwd_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chip_clear_input(clr), .pins(pins), .drive_level(drive_level), .outs(outs), .sys_reset(sys_reset),
    .cpu_clk_en(cpu_clk_en), .primary_oscillator(osc), .irq_req(irq_req), .irq_vector(irq_vector));
  rwd_ext_model rwd_ext_model_i (.pclk(pclk), .chip_clear_input(clr), .pins(pins));
  // Clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // One APB transfer, held until ready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input string n, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(n, rd, e);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask
  task automatic mode_is(input logic [3:0] e);
    apb(1'b0, `RWD_OFF_STAT, 32'h0);
    check("mode", rd[11:8], e);
  endtask
  task automatic finish_test();
    if (errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (95000) @(posedge pclk);
    errors++;
    finish_test();
  end
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    void'($urandom(32'hABE1));
    drive_level = 4'($urandom);
    m = $urandom_range(31);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("opt", `RWD_OFF_OPT, 32'h0);
    apb(1'b0, 12'h040, 32'h0);
    check("unmapped", rd, 32'h0);
    check("slverr", er, 1'b1);
    wr(`RWD_OFF_WAKEEN, m);
    wr(`RWD_OFF_INTEN, ~m);
    rdchk("wake", `RWD_OFF_WAKEEN, m);
    rdchk("inten", `RWD_OFF_INTEN, 31 - m);
    // Clear pin sequencing
    wr(`RWD_OFF_OPT, 32'hA00);
    rwd_ext_model_i.clear_pulse($urandom_range(1, 4));
    settle(2);
    check("rst", sys_reset, 1);
    check("rst outs", outs, 4'hA);
    rdchk("wake rst", `RWD_OFF_WAKEEN, 0);
    k = 0;
    while (sys_reset !== 1'b0 && k < 40000) begin
      @(posedge pclk);
      k++;
    end
    check("release", k <= 32770, 1);
    settle(2);
    check("outs", outs, drive_level);
    // Level-direction counting across both ends
    wr(`RWD_OFF_CTRL, 32'h4);
    wr(`RWD_OFF_COUNT, 32'h9999);
    rwd_ext_model_i.count(1'b1, 1);
    apb(1'b0, `RWD_OFF_COUNT, 32'h0);
    up = (rd[15:0] === 16'h0000);
    check("step", up || rd[15:0] === 16'h9998, 1);
    wr(`RWD_OFF_COUNT, 32'h0);
    rwd_ext_model_i.count(1'b1, 1);
    rdchk("step2", `RWD_OFF_COUNT, up ? 32'h1 : 32'h9999);
    rwd_ext_model_i.count(1'b0, 2);
    rdchk("back", `RWD_OFF_COUNT, up ? 32'h9999 : 32'h1);
    // Phase-direction counting: up when direction key was low
    wr(`RWD_OFF_CTRL, 32'h5);
    wr(`RWD_OFF_COUNT, 32'h500);
    rwd_ext_model_i.count(1'b0, 2);
    rdchk("phase up", `RWD_OFF_COUNT, 32'h502);
    rwd_ext_model_i.count(1'b1, 1);
    rdchk("phase dn", `RWD_OFF_COUNT, 32'h501);
    wr(`RWD_OFF_INTEN, 32'h10);
    settle(2);
    check("cnt vec", {irq_req, irq_vector}, {1'b1, `RWD_VEC_CNT});
    // Priority, masking and shared vector
    wr(`RWD_OFF_STAT, 32'h1F);
    wr(`RWD_OFF_INTEN, 32'h05);
    rwd_ext_model_i.ext(1'b1);
    rwd_ext_model_i.underflow();
    settle(2);
    check("prio", irq_vector, `RWD_VEC_EXT);
    rwd_ext_model_i.ext(1'b0);
    wr(`RWD_OFF_STAT, 32'h1);
    settle(2);
    check("tmr vec", irq_vector, `RWD_VEC_TMR);
    wr(`RWD_OFF_INTEN, 32'h0);
    settle(2);
    check("masked", irq_req, 0);
    wr(`RWD_OFF_STAT, 32'h1F);
    wr(`RWD_OFF_INTEN, 32'h2);
    rwd_ext_model_i.switches(4'($urandom_range(1, 14)));
    settle(2);
    check("port vec", {irq_req, irq_vector}, {1'b1, `RWD_VEC_EXT});
    // Interrupt in clock pause, then back to pause
    wr(`RWD_OFF_STAT, 32'h1F);
    wr(`RWD_OFF_CMD, `RWD_CMD_IRET);
    mode_is(4'h1);
    wr(`RWD_OFF_INTEN, 32'h8);
    wr(`RWD_OFF_CMD, `RWD_CMD_HALT);
    settle(2);
    check("halt clk", cpu_clk_en, 0);
    mode_is(4'h2);
    k = 0;
    while (irq_req !== 1'b1 && k < 34000) begin
      @(posedge pclk);
      k++;
    end
    settle(2);
    check("div vec", {cpu_clk_en, irq_vector}, {1'b1, `RWD_VEC_DIV});
    mode_is(4'h8);
    wr(`RWD_OFF_STAT, 32'h1F);
    wr(`RWD_OFF_CMD, `RWD_CMD_IRET);
    settle(2);
    check("rehalt", cpu_clk_en, 0);
    wr(`RWD_OFF_INTEN, 32'h0);
    wr(`RWD_OFF_WAKEEN, 32'h1);
    rwd_ext_model_i.ext(1'b1);
    settle(3);
    check("wake", cpu_clk_en, 1);
    mode_is(4'h1);
    rwd_ext_model_i.ext(1'b0);
    // Oscillator stop per oscillator option
    wr(`RWD_OFF_OPT, 32'h8);
    wr(`RWD_OFF_STAT, 32'h1F);
    wr(`RWD_OFF_CMD, `RWD_CMD_STOP);
    settle(2);
    check("hold", osc, 0);
    rwd_ext_model_i.ext(1'b1);
    settle(3);
    check("hold kept", osc, 0);
    rwd_ext_model_i.ext(1'b0);
    @(posedge pclk) presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    settle(2);
    check("hold reset", osc, 1);
    @(posedge pclk) drive_level <= 4'($urandom);
    wr(`RWD_OFF_OPT, 32'h10);
    wr(`RWD_OFF_CMD, `RWD_CMD_STOP);
    mode_is(4'h1);
    wr(`RWD_OFF_OPT, 32'h0);
    wr(`RWD_OFF_WAKEEN, 32'h1);
    wr(`RWD_OFF_CMD, `RWD_CMD_STOP);
    rwd_ext_model_i.ext(1'b1);
    settle(3);
    check("hold wake", osc, 1);
    rwd_ext_model_i.ext(1'b0);
    // Centisecond counting
    wr(`RWD_OFF_CTRL, 32'h6);
    wr(`RWD_OFF_COUNT, 32'h0);
    repeat (3270) @(posedge pclk);
    apb(1'b0, `RWD_OFF_COUNT, 32'h0);
    check("csec", rd[15:0] inside {16'h0009, 16'h0010, 16'h0011}, 1);
    settle(1);
    check("outs run", outs, drive_level);
    // Four-switch clear
    wr(`RWD_OFF_OPT, 32'h4);
    rwd_ext_model_i.switches(4'hF);
    settle(3);
    check("sw clear", sys_reset, 1);
    finish_test();
  end
endmodule
